//--- hw/pd_sink_pkg.sv
// Package: constants, types and timing for the PD sink port controller
package pd_sink_pkg;

  localparam int unsigned CLK_HZ = 25000000;
  // BMC unit interval at 300 kbit/s, in ns
  localparam int unsigned UI_NS = 3333;
  localparam int unsigned UI_CYC = (UI_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned HALF_CYC = UI_CYC / 2;
  // Channel must be idle this long before we transmit, in ns
  localparam int unsigned IDLE_NS = 20000;
  localparam int unsigned IDLE_CYC = (IDLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // Acknowledge timeout, in us
  localparam int unsigned ACK_TO_US = 1000;
  localparam int unsigned ACK_TO_CYC = ACK_TO_US * (CLK_HZ / 1000000);
  localparam int unsigned RETRY_MAX = 2;
  // Attach debounce, in us
  localparam int unsigned ATTACH_US = 150;
  localparam int unsigned ATTACH_CYC = ATTACH_US * (CLK_HZ / 1000000);

  localparam int unsigned CHUNK_BYTES = 26;
  localparam int unsigned EXT_MAX_BYTES = 260;
  localparam int unsigned LEGACY_MAX_BYTES = 28;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned BYTE_W = 8;

  localparam logic [15:0] PPS_MIN_MV = 16'h0bb8;  // 3000 mV
  localparam logic [15:0] PPS_MAX_MV = 16'h55f0;  // 22000 mV

  typedef enum logic [2:0]
  {
    TX_IDLE = 3'b000,
    TX_WAIT = 3'b001,
    TX_SEND = 3'b010,
    TX_ACK = 3'b011,
    TX_DONE = 3'b100,
    TX_FAIL = 3'b101
  } tx_state_t;

  typedef struct packed
  {
    logic last;
    logic [7:0] data;
  } stream_byte_t;

  typedef struct packed
  {
    logic [15:0] volt_mv;
    logic [15:0] curr_ma;
  } pps_req_t;

endpackage : pd_sink_pkg

//--- hw/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign wr_ready_out = (cnt_q != DEPTH[AW:0]);
  assign rd_valid_out = (cnt_q != '0);
  assign rd_data_out = mem_q[rp_q];
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem_q[wp_q] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop)
      begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

//--- hw/pd_sink_port.sv
// Sink-side PD port controller: attach, BMC transmit/receive, protection
`timescale 1ns/1ps
// What this block does
// [RL1] All traffic with the adapter is biphase-mark coded on the active CC wire.
// [RL2] The port never drives CC while it is receiving; the link is half-duplex.
// [RL3] A frame starts only after CC has been idle for a minimum gap.
// [RL4] Attach and plug orientation are found from which CC wire sees the pull-up.
// [RL5] The pull-down is presented on both CC wires so the port is a sink until shutdown.
// [RL6] Extended messages up to 260 bytes are received as chunks.
// [RL7] Messages stay within legacy length unless long messages were negotiated.
// [RL8] Programmable-supply requests are accepted only between 3 V and 22 V.
// [RL9] Power draw is held back when the input supply sags toward undervoltage.
// [RL10] The VCONN switch is driven to the unused CC wire only while attached.
// [RL11] D+/D- legacy charger detection and emulation run in source or sink role.
// [RL12] An input overvoltage, when enabled, shuts the port down: pull-down, attach, VCONN, legacy lines and new frames stop.
// [RL13] After shutdown the port stays off until the supply is removed.
// [RL14] Each chunk carries at most 26 bytes and following chunks are requested.
// [RL15] A frame received after sending counts as the acknowledge and unacknowledged frames are retried; a retry sends only what the source refills.
module pd_sink_port
  import pd_sink_pkg::*;
#(
  parameter int unsigned ACK_TO = ACK_TO_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic cc1_in,
  input wire logic cc2_in,
  input wire logic cc1_rp_seen_in,
  input wire logic cc2_rp_seen_in,
  output logic cc_out,
  output logic cc_oe_out,
  output logic rd_en_out,
  output logic vconn1_en_out,
  output logic vconn2_en_out,
  output logic attached_out,
  output logic flip_out,
  input wire stream_byte_t tx_byte_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  input wire logic [2:0] tx_msg_id_in,
  output logic tx_done_out,
  output logic tx_fail_out,
  input wire logic ext_nego_in,
  output logic len_err_out,
  output stream_byte_t rx_byte_out,
  output logic rx_valid_out,
  output logic chunk_req_out,
  input wire pps_req_t pps_req_in,
  input wire logic pps_req_valid_in,
  output pps_req_t pps_req_out,
  output logic pps_req_reject_out,
  input wire logic uv_warn_in,
  output logic draw_limit_out,
  input wire logic legacy_src_role_in,
  input wire logic legacy_en_in,
  output logic dp_out,
  output logic dp_oe_out,
  output logic dm_out,
  output logic dm_oe_out,
  input wire logic dp_in,
  input wire logic dm_in,
  output logic legacy_detected_out,
  input wire logic ovp_shutdown_en_in,
  input wire logic adapter_input_supply_ovp_in,
  input wire logic adapter_input_supply_present_in,
  output logic port_shutdown_out
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] s_cc1_q, s_cc2_q, s_rp1_q, s_rp2_q, s_ovp_q, s_pres_q, s_dp_q, s_dm_q;
  logic f_cc1_q, f_cc2_q, f_rp1_q, f_rp2_q, f_ovp_q, f_pres_q, f_dp_q, f_dm_q;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      {s_cc1_q, s_cc2_q, s_rp1_q, s_rp2_q} <= '0;
      {s_ovp_q, s_pres_q, s_dp_q, s_dm_q} <= '0;
    end
    else
    begin
      s_cc1_q <= {s_cc1_q[1:0], cc1_in};
      s_cc2_q <= {s_cc2_q[1:0], cc2_in};
      s_rp1_q <= {s_rp1_q[1:0], cc1_rp_seen_in};
      s_rp2_q <= {s_rp2_q[1:0], cc2_rp_seen_in};
      s_ovp_q <= {s_ovp_q[1:0], adapter_input_supply_ovp_in};
      s_pres_q <= {s_pres_q[1:0], adapter_input_supply_present_in};
      s_dp_q <= {s_dp_q[1:0], dp_in};
      s_dm_q <= {s_dm_q[1:0], dm_in};
    end
  end

  // Filtered level changes only once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      {f_cc1_q, f_cc2_q, f_rp1_q, f_rp2_q, f_ovp_q, f_pres_q, f_dp_q, f_dm_q} <= '0;
    end
    else
    begin
      if (s_cc1_q[1] == s_cc1_q[2]) f_cc1_q <= s_cc1_q[2];
      if (s_cc2_q[1] == s_cc2_q[2]) f_cc2_q <= s_cc2_q[2];
      if (s_rp1_q[1] == s_rp1_q[2]) f_rp1_q <= s_rp1_q[2];
      if (s_rp2_q[1] == s_rp2_q[2]) f_rp2_q <= s_rp2_q[2];
      if (s_ovp_q[1] == s_ovp_q[2]) f_ovp_q <= s_ovp_q[2];
      if (s_pres_q[1] == s_pres_q[2]) f_pres_q <= s_pres_q[2];
      if (s_dp_q[1] == s_dp_q[2]) f_dp_q <= s_dp_q[2];
      if (s_dm_q[1] == s_dm_q[2]) f_dm_q <= s_dm_q[2];
    end
  end

  // ----------------------------------------------------------------
  // Protection latch and attach detection
  // ----------------------------------------------------------------
  logic shut_q;
  logic pres_d1_q;
  logic [15:0] att_cnt_q;
  logic attached_q;
  logic flip_q;
  logic rp_any;

  assign rp_any = f_rp1_q ^ f_rp2_q;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      shut_q <= 1'b0;
      pres_d1_q <= 1'b0;
    end
    else
    begin
      pres_d1_q <= f_pres_q;
      if (ovp_shutdown_en_in && f_ovp_q) shut_q <= 1'b1;  // [RL12]
      else if (pres_d1_q && !f_pres_q) shut_q <= 1'b0;  // [RL13] only a supply removal clears it
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      att_cnt_q <= '0;
      attached_q <= 1'b0;
      flip_q <= 1'b0;
    end
    else if (shut_q || !rp_any)
    begin
      att_cnt_q <= '0;
      attached_q <= 1'b0;
    end
    else if (!attached_q)
    begin
      if (att_cnt_q == 16'(ATTACH_CYC - 1))
      begin
        attached_q <= 1'b1;  // [RL4]
        flip_q <= f_rp2_q;  // [RL4]
      end
      else
      begin
        att_cnt_q <= att_cnt_q + 16'h0001;
      end
    end
  end

  assign rd_en_out = !shut_q;  // [RL5]
  assign attached_out = attached_q;
  assign flip_out = flip_q;
  assign port_shutdown_out = shut_q;
  // [RL10] VCONN goes to the CC wire not carrying the channel
  assign vconn1_en_out = attached_q && flip_q;
  assign vconn2_en_out = attached_q && !flip_q;
  assign draw_limit_out = uv_warn_in || !attached_q;  // [RL9]

  // ----------------------------------------------------------------
  // Channel activity and BMC receive
  // ----------------------------------------------------------------
  logic cc_rx;
  logic cc_rx_d1_q;
  logic [9:0] idle_cnt_q;
  logic [7:0] rx_tmr_q;
  logic rx_mid_q;
  logic [7:0] rx_sh_q;
  logic [3:0] rx_bits_q;
  logic rx_busy;
  logic tx_active;

  assign cc_rx = flip_q ? f_cc2_q : f_cc1_q;
  assign rx_busy = (idle_cnt_q < 10'(IDLE_CYC));

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cc_rx_d1_q <= 1'b0;
      idle_cnt_q <= '0;
      rx_tmr_q <= '0;
      rx_mid_q <= 1'b0;
      rx_sh_q <= '0;
      rx_bits_q <= '0;
    end
    else
    begin
      cc_rx_d1_q <= cc_rx;
      if (tx_active || cc_rx != cc_rx_d1_q) idle_cnt_q <= '0;  // [RL3]
      else if (rx_busy) idle_cnt_q <= idle_cnt_q + 10'h001;
      // Decode: a mid-interval transition marks a one  [RL1]
      if (!tx_active && cc_rx != cc_rx_d1_q)
      begin
        if (rx_tmr_q > 8'(HALF_CYC + HALF_CYC / 2) || rx_mid_q)
        begin
          rx_sh_q <= {rx_mid_q, rx_sh_q[7:1]};
          rx_bits_q <= (rx_bits_q == 4'h7) ? 4'h0 : rx_bits_q + 4'h1;
          rx_mid_q <= 1'b0;
          rx_tmr_q <= '0;
        end
        else
        begin
          rx_mid_q <= 1'b1;
        end
      end
      else if (rx_tmr_q != 8'hff)
      begin
        rx_tmr_q <= rx_tmr_q + 8'h01;
      end
    end
  end

  // Receive framing: bytes out, chunk requests, acknowledge trigger
  logic [8:0] rx_len_q;
  logic [4:0] rx_chunk_q;
  logic rx_byte_v;
  logic ack_pend_q;

  assign rx_byte_v = !tx_active && cc_rx != cc_rx_d1_q && rx_bits_q == 4'h7
    && (rx_tmr_q > 8'(HALF_CYC + HALF_CYC / 2) || rx_mid_q);

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rx_byte_out <= '0;
      rx_valid_out <= 1'b0;
      rx_len_q <= '0;
      rx_chunk_q <= '0;
      chunk_req_out <= 1'b0;
      len_err_out <= 1'b0;
      ack_pend_q <= 1'b0;
    end
    else
    begin
      rx_valid_out <= 1'b0;
      chunk_req_out <= 1'b0;
      len_err_out <= 1'b0;
      if (rx_byte_v)
      begin
        rx_byte_out <= '{last: 1'b0, data: {rx_mid_q, rx_sh_q[7:1]}};
        rx_valid_out <= 1'b1;
        rx_len_q <= rx_len_q + 9'h001;
        rx_chunk_q <= (rx_chunk_q == 5'(CHUNK_BYTES - 1)) ? '0 : rx_chunk_q + 5'h01;
        if (rx_chunk_q == 5'(CHUNK_BYTES - 1)) chunk_req_out <= 1'b1;  // [RL14]
        if (rx_len_q >= (ext_nego_in ? 9'(EXT_MAX_BYTES) : 9'(LEGACY_MAX_BYTES)))
          len_err_out <= 1'b1;  // [RL6] [RL7]
      end
      else if (!rx_busy && rx_len_q != '0)
      begin
        rx_len_q <= '0;
        rx_chunk_q <= '0;
        ack_pend_q <= 1'b1;  // [RL15] frame ended: taken as the acknowledge in TX_ACK
      end
      else if (tx_active)
      begin
        ack_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit path: FIFO, collision avoidance, BMC encoder, retry
  // ----------------------------------------------------------------
  stream_byte_t fifo_out;
  logic fifo_valid;
  logic fifo_pop;
  tx_state_t tx_q;
  logic [7:0] tx_sh_q;
  logic [3:0] tx_bit_q;
  logic [7:0] tx_tmr_q;
  logic tx_lvl_q;
  logic tx_last_q;
  logic [1:0] retry_q;
  logic [15:0] ack_cnt_q;
  logic [2:0] msg_id_q;

  byte_fifo #(.WIDTH($bits(stream_byte_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .wr_data_in(tx_byte_in),
    .wr_valid_in(tx_valid_in),
    .wr_ready_out(tx_ready_out),
    .rd_data_out(fifo_out),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_pop)
  );

  assign tx_active = (tx_q == TX_SEND);
  assign fifo_pop = (tx_q == TX_WAIT && !rx_busy && attached_q && fifo_valid)
    || (tx_q == TX_SEND && tx_bit_q == 4'h8 && !tx_last_q && fifo_valid);
  assign cc_out = tx_lvl_q;
  assign cc_oe_out = tx_active;  // [RL2]

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tx_q <= TX_IDLE;
      tx_sh_q <= '0;
      tx_bit_q <= '0;
      tx_tmr_q <= '0;
      tx_lvl_q <= 1'b0;
      tx_last_q <= 1'b0;
      retry_q <= '0;
      ack_cnt_q <= '0;
      msg_id_q <= '0;
    end
    else
    begin
      unique case (tx_q)
        TX_IDLE:
        begin
          retry_q <= '0;
          if (fifo_valid && !shut_q)
          begin
            msg_id_q <= tx_msg_id_in;
            tx_q <= TX_WAIT;
          end
        end
        TX_WAIT:
        begin
          if (shut_q) tx_q <= TX_FAIL;
          else if (fifo_pop)  // [RL3] only after idle gap, [RL2] never while receiving
          begin
            tx_sh_q <= fifo_out.data;
            tx_last_q <= fifo_out.last;
            tx_bit_q <= '0;
            tx_tmr_q <= '0;
            tx_q <= TX_SEND;
          end
        end
        TX_SEND:
        begin
          tx_tmr_q <= (tx_tmr_q == 8'(UI_CYC - 1)) ? '0 : tx_tmr_q + 8'h01;
          if (tx_tmr_q == '0) tx_lvl_q <= !tx_lvl_q;  // [RL1] edge at every bit start
          else if (tx_tmr_q == 8'(HALF_CYC) && tx_sh_q[0]) tx_lvl_q <= !tx_lvl_q;  // [RL1]
          if (tx_tmr_q == 8'(UI_CYC - 1))
          begin
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
          end
          if (tx_bit_q == 4'h8)
          begin
            if (fifo_pop)
            begin
              tx_sh_q <= fifo_out.data;
              tx_last_q <= fifo_out.last;
              tx_bit_q <= '0;
            end
            else if (tx_last_q)
            begin
              ack_cnt_q <= '0;
              tx_q <= TX_ACK;
            end
          end
        end
        TX_ACK:
        begin
          ack_cnt_q <= ack_cnt_q + 16'h0001;
          // Acknowledge arrives as a short frame; seen as a finished receive
          if (ack_pend_q) tx_q <= TX_DONE;  // [RL15]
          else if (ack_cnt_q == 16'(ACK_TO - 1))
          begin
            // Retry limitation: the sent frame is not kept, so a retry resends
            // what the source refills; a full frame buffer was traded for area.
            if (retry_q == 2'(RETRY_MAX)) tx_q <= TX_FAIL;
            else
            begin
              retry_q <= retry_q + 2'b01;  // [RL15]
              tx_q <= TX_WAIT;
            end
          end
        end
        TX_DONE: tx_q <= TX_IDLE;
        TX_FAIL: tx_q <= TX_IDLE;
        default: tx_q <= TX_IDLE;
      endcase
    end
  end

  assign tx_done_out = (tx_q == TX_DONE);
  assign tx_fail_out = (tx_q == TX_FAIL);

  // ----------------------------------------------------------------
  // PPS request check and legacy charger lines
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pps_req_out <= '0;
      pps_req_reject_out <= 1'b0;
    end
    else
    begin
      pps_req_reject_out <= 1'b0;
      if (pps_req_valid_in)
      begin
        if (pps_req_in.volt_mv >= PPS_MIN_MV && pps_req_in.volt_mv <= PPS_MAX_MV && attached_q)
          pps_req_out <= pps_req_in;  // [RL8]
        else
          pps_req_reject_out <= 1'b1;  // [RL8]
      end
    end
  end

  // Source role drives D- to mirror D+ (short emulation); sink role watches for it
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      dp_out <= 1'b0;
      dp_oe_out <= 1'b0;
      dm_out <= 1'b0;
      dm_oe_out <= 1'b0;
      legacy_detected_out <= 1'b0;
    end
    else
    begin
      dp_oe_out <= legacy_en_in && !legacy_src_role_in && !shut_q;  // [RL11]
      dp_out <= 1'b1;
      dm_oe_out <= legacy_en_in && legacy_src_role_in && !shut_q;  // [RL11]
      dm_out <= f_dp_q;
      legacy_detected_out <= legacy_en_in && !shut_q
        && (legacy_src_role_in ? f_dp_q : f_dm_q);  // [RL11]
    end
  end
endmodule : pd_sink_port

//--- verif/pd_sink_chk.sv
// Checker: port-level assertions for the PD sink port controller
`timescale 1ns/1ps
module pd_sink_chk
  import pd_sink_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic cc1_in,
  input wire logic cc2_in,
  input wire logic cc_out,
  input wire logic cc_oe_out,
  input wire logic rd_en_out,
  input wire logic vconn1_en_out,
  input wire logic vconn2_en_out,
  input wire logic attached_out,
  input wire logic flip_out,
  input wire logic tx_done_out,
  input wire logic tx_fail_out,
  input wire pps_req_t pps_req_in,
  input wire logic pps_req_valid_in,
  input wire pps_req_t pps_req_out,
  input wire logic pps_req_reject_out,
  input wire logic uv_warn_in,
  input wire logic draw_limit_out,
  input wire logic ovp_shutdown_en_in,
  input wire logic adapter_input_supply_ovp_in,
  input wire logic adapter_input_supply_present_in,
  input wire logic port_shutdown_out
);
  logic [7:0] oe_hist_q;
  logic [1:0] cc_q;
  int unsigned idle_q;

  // ----------------------------------------
  // Channel idle counter
  // ----------------------------------------
  // Own echo on CC is masked, so only far-side traffic restarts the gap
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      oe_hist_q <= '0;
      cc_q <= '0;
      idle_q <= 0;
    end
    else
    begin
      oe_hist_q <= {oe_hist_q[6:0], cc_oe_out};
      cc_q <= {cc2_in, cc1_in};
      if ({cc2_in, cc1_in} != cc_q && !cc_oe_out && oe_hist_q == 8'h00) idle_q <= 0;
      else if (idle_q < 1000) idle_q <= idle_q + 1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_tx_start;
    $rose(cc_oe_out);
  endsequence
  sequence s_ovp_held;
    (ovp_shutdown_en_in && adapter_input_supply_ovp_in)[*8];
  endsequence
  sequence s_pps_bad;
    pps_req_valid_in && (pps_req_in.volt_mv < PPS_MIN_MV || pps_req_in.volt_mv > PPS_MAX_MV || !attached_out);
  endsequence

  AST_BMC_EDGE: assert property (cc_oe_out && $changed(cc_out) |-> ##[1:84] ($changed(cc_out) || !cc_oe_out))
    else $error("cc edge missing in a bit cell");
  AST_IDLE_GAP: assert property (s_tx_start |-> idle_q >= 450)
    else $error("frame started on a busy channel");
  AST_TX_ATTACHED: assert property (cc_oe_out |-> attached_out && !port_shutdown_out)
    else $error("cc driven while detached or shut down");
  AST_VCONN1: assert property (vconn1_en_out |-> attached_out && flip_out && !vconn2_en_out)
    else $error("vconn1 on wrong wire");
  AST_VCONN2: assert property (vconn2_en_out |-> attached_out && !flip_out)
    else $error("vconn2 on wrong wire");
  AST_RD_SINK: assert property (!port_shutdown_out |-> rd_en_out)
    else $error("pull-down off while running");
  AST_DRAW_HI: assert property ((uv_warn_in || !attached_out)[*4] |-> draw_limit_out)
    else $error("draw not limited");
  AST_DRAW_LO: assert property ((!uv_warn_in && attached_out)[*4] |-> !draw_limit_out)
    else $error("draw limited without cause");
  AST_PPS_REJECT: assert property (s_pps_bad |-> ##[1:2] pps_req_reject_out)
    else $error("bad supply request not rejected");
  AST_PPS_HOLD: assert property (!pps_req_valid_in && !$past(pps_req_valid_in) && attached_out |=> $stable(pps_req_out) || !attached_out)
    else $error("supply request changed unasked");
  AST_TX_PULSE: assert property (tx_done_out || tx_fail_out |=> !tx_done_out && !tx_fail_out)
    else $error("transmit result longer than a pulse");
  AST_OVP_SHUT: assert property (s_ovp_held |-> port_shutdown_out)
    else $error("overvoltage did not shut the port");
  AST_SHUT_HOLD: assert property ($fell(port_shutdown_out) |-> !adapter_input_supply_present_in)
    else $error("shutdown cleared with supply present");
endmodule : pd_sink_chk

bind pd_sink_port pd_sink_chk chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .cc1_in(cc1_in), .cc2_in(cc2_in),
  .cc_out(cc_out), .cc_oe_out(cc_oe_out), .rd_en_out(rd_en_out), .vconn1_en_out(vconn1_en_out),
  .vconn2_en_out(vconn2_en_out), .attached_out(attached_out), .flip_out(flip_out), .tx_done_out(tx_done_out),
  .tx_fail_out(tx_fail_out), .pps_req_in(pps_req_in), .pps_req_valid_in(pps_req_valid_in),
  .pps_req_out(pps_req_out), .pps_req_reject_out(pps_req_reject_out), .uv_warn_in(uv_warn_in),
  .draw_limit_out(draw_limit_out), .ovp_shutdown_en_in(ovp_shutdown_en_in),
  .adapter_input_supply_ovp_in(adapter_input_supply_ovp_in),
  .adapter_input_supply_present_in(adapter_input_supply_present_in), .port_shutdown_out(port_shutdown_out));

//--- verif/pd_source_model.sv
// Behavioural adapter-side source model on the CC wire
`timescale 1ns/1ps
module pd_source_model
  import pd_sink_pkg::*;
#(
  parameter logic [7:0] ACK_BYTE = 8'h96
) (
  input wire logic clk_in,
  input wire logic attach_in,
  input wire logic ack_en_in,
  input wire logic port_oe_in,
  output logic rp1_out,
  output logic rp2_out,
  output logic cc_drv_out,
  output logic cc_oe_out
);
  logic lvl = 1'b0;

  // Plug sits flipped: the pull-up is seen on CC2 only
  assign rp1_out = 1'b0;
  assign rp2_out = attach_in;

  initial
  begin
    cc_oe_out = 1'b0;
    cc_drv_out = 1'b0;
  end

  // Answer only after the port lets go of CC; a short gap avoids overlap
  always
  begin
    @(negedge port_oe_in);
    if (ack_en_in)
    begin
      repeat (20) @(posedge clk_in);
      cc_oe_out = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
        lvl = !lvl;
        cc_drv_out = lvl;
        repeat (HALF_CYC) @(posedge clk_in);
        if (ACK_BYTE[i]) lvl = !lvl;
        cc_drv_out = lvl;
        repeat (UI_CYC - HALF_CYC) @(posedge clk_in);
      end
      cc_oe_out = 1'b0;
    end
  end
endmodule : pd_source_model

//--- verif/usb_pd_sink_port_controller_bench.sv
// Self-checking testbench for the PD sink port controller
`timescale 1ns/1ps
module usb_pd_sink_port_controller_bench;
  import pd_sink_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic attach = 1'b0;
  logic ack_en = 1'b0;
  logic tx_valid = 1'b0;
  logic uv_warn = 1'b0;
  logic ovp_en = 1'b0;
  logic ovp = 1'b0;
  logic leg = 1'b0;
  logic present = 1'b1;
  logic pps_valid = 1'b0;
  logic [2:0] msg_id = 3'h0;
  stream_byte_t tx_byte = '0;
  pps_req_t pps_req = '0;
  pps_req_t pps_out;
  logic cc1, cc2, rp1, rp2, p_drv, p_oe, cc_out, cc_oe, rd_en, vc1, vc2, att, flip;
  logic tx_ready, tx_done, tx_fail, pps_rej, draw_lim, shut, dp_oe, leg_det;
  int err_count = 0;
  int num_checks = 0;
  int frames = 0;

  always #20 clk_in = ~clk_in;
  // Released CC sits at the pull-down level
  assign cc1 = (cc_oe && !flip) ? cc_out : 1'b0;
  assign cc2 = (cc_oe && flip) ? cc_out : (p_oe ? p_drv : 1'b0);
  always @(posedge cc_oe) frames++;

  pd_sink_port #(.ACK_TO(1500)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .cc1_in(cc1), .cc2_in(cc2),
    .cc1_rp_seen_in(rp1), .cc2_rp_seen_in(rp2), .cc_out(cc_out), .cc_oe_out(cc_oe), .rd_en_out(rd_en),
    .vconn1_en_out(vc1), .vconn2_en_out(vc2), .attached_out(att), .flip_out(flip), .tx_byte_in(tx_byte),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .tx_msg_id_in(msg_id), .tx_done_out(tx_done),
    .tx_fail_out(tx_fail), .ext_nego_in(1'b0), .len_err_out(), .rx_byte_out(), .rx_valid_out(),
    .chunk_req_out(), .pps_req_in(pps_req), .pps_req_valid_in(pps_valid), .pps_req_out(pps_out),
    .pps_req_reject_out(pps_rej), .uv_warn_in(uv_warn), .draw_limit_out(draw_lim), .legacy_src_role_in(1'b0),
    .legacy_en_in(leg), .dp_out(), .dp_oe_out(dp_oe), .dm_out(), .dm_oe_out(), .dp_in(1'b0), .dm_in(leg),
    .legacy_detected_out(leg_det), .ovp_shutdown_en_in(ovp_en), .adapter_input_supply_ovp_in(ovp),
    .adapter_input_supply_present_in(present), .port_shutdown_out(shut));

  pd_source_model src (.clk_in(clk_in), .attach_in(attach), .ack_en_in(ack_en), .port_oe_in(cc_oe),
    .rp1_out(rp1), .rp2_out(rp2), .cc_drv_out(p_drv), .cc_oe_out(p_oe));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_attach;
    @(negedge clk_in) attach = 1'b1;
    cyc(3000);
    check(att, 1'b0);
    for (int i = 0; i < 2000 && att !== 1'b1; i++) cyc(1);
    check({att, flip}, 2'b11);
    check({vc1, vc2}, 2'b10);
    check(rd_en, 1'b1);
  endtask : t_attach

  task automatic t_draw;
    check(draw_lim, 1'b0);
    @(negedge clk_in) uv_warn = 1'b1;
    cyc(6);
    check(draw_lim, 1'b1);
    @(negedge clk_in) uv_warn = 1'b0;
    cyc(6);
    check(draw_lim, 1'b0);
  endtask : t_draw

  // The reply may land on any of the next three edges
  task automatic t_pps(input logic [15:0] mv, input logic rej_exp);
    logic rej;
    @(negedge clk_in);
    pps_req = '{volt_mv: mv, curr_ma: 16'h0bb8};
    pps_valid = 1'b1;
    @(negedge clk_in) pps_valid = 1'b0;
    rej = pps_rej;
    repeat (2)
    begin
      cyc(1);
      rej = rej | pps_rej;
    end
    check(rej, rej_exp);
    if (!rej_exp) check(pps_out.volt_mv, mv);
  endtask : t_pps

  task automatic t_tx(input logic ack, input int exp_frames);
    @(negedge clk_in);
    frames = 0;
    ack_en = ack;
    msg_id = msg_id + 3'h1;
    tx_byte = '{last: 1'b1, data: 8'h3c};
    tx_valid = 1'b1;
    // A retry only resends what is buffered, so one copy per expected attempt
    repeat (ack ? 1 : RETRY_MAX + 1)
      do @(posedge clk_in); while (tx_ready !== 1'b1);
    @(negedge clk_in) tx_valid = 1'b0;
    for (int i = 0; i < 12000 && tx_done !== 1'b1 && tx_fail !== 1'b1; i++) cyc(1);
    check({tx_done, tx_fail}, {ack, !ack});
    check(frames, exp_frames);
  endtask : t_tx

  task automatic t_legacy;
    @(negedge clk_in) leg = 1'b1;
    cyc(6);
    check({dp_oe, leg_det}, 2'b11);
    @(negedge clk_in) leg = 1'b0;
    cyc(6);
    check({dp_oe, leg_det}, 2'b00);
  endtask : t_legacy

  // Shutdown must outlive the fault and clear only on supply removal
  task automatic t_ovp;
    @(negedge clk_in);
    ovp_en = 1'b1;
    ovp = 1'b1;
    cyc(10);
    check({shut, rd_en}, 2'b10);
    @(negedge clk_in) ovp = 1'b0;
    cyc(20);
    check(shut, 1'b1);
    @(negedge clk_in) present = 1'b0;
    cyc(10);
    check(shut, 1'b0);
    @(negedge clk_in) present = 1'b1;
  endtask : t_ovp

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    cyc(2);
    check({rd_en, draw_lim, tx_ready, att}, 4'b1110);
    @(negedge clk_in) rst_b_in = 1'b1;
    t_attach();
    t_draw();
    t_pps(16'h0bb7, 1'b1);
    t_pps(16'h0bb8, 1'b0);
    t_pps(16'h55f0, 1'b0);
    t_pps(16'h55f1, 1'b1);
    t_tx(1'b1, 1);
    t_tx(1'b0, 3);
    t_legacy();
    t_ovp();
    give_verdict();
  end

  initial
  begin
    #(40 * 60000);
    err_count++;
    give_verdict();
  end
endmodule : usb_pd_sink_port_controller_bench
